// File: logic/codec_consts.vh
`ifndef CODEC_CONSTS_VH
`define CODEC_CONSTS_VH

// Control word layout, as delivered by the serial-port framer.
`define CW_CLOR_BIT 15
`define CW_MCE_BIT 14
`define CW_RREQ_BIT 13
`define CW_IDX_HI 11
`define CW_IDX_LO 8
`define CW_DATA_HI 7

// Index addresses.
`define IDX_LEFT_INPUT 4'h0
`define IDX_RIGHT_INPUT 4'h1
`define IDX_LEFT_AUX1 4'h2
`define IDX_RIGHT_AUX1 4'h3
`define IDX_LEFT_AUX2 4'h4
`define IDX_RIGHT_AUX2 4'h5
`define IDX_LEFT_OUTPUT 4'h6
`define IDX_RIGHT_OUTPUT 4'h7
`define IDX_SAMPLE_FORMAT 4'h8
`define IDX_INTERFACE_CFG 4'h9
`define IDX_PIN_CONTROL 4'hA
`define IDX_MISC_INFO 4'hC
`define IDX_DIGITAL_MIX 4'hD

// One bit per index; indices 11, 14 and 15 hold no register.
`define IDX_VALID_MAP 16'h37FF

// Reset values.
`define RST_INPUT 8'h00
`define RST_AUX 8'h80
`define RST_OUTPUT 8'h80
`define RST_SAMPLE_FORMAT 8'h00
`define RST_INTERFACE_CFG 8'h08
`define RST_PIN_CONTROL 8'h00
`define RST_MISC_INFO 8'h00
`define RST_DIGITAL_MIX 8'h00
`define RST_READBACK 16'hE000
`define RST_MCE 1'b1
`define RST_CLOR 1'b1

// Implemented (non-reserved) bits of each register.
`define MASK_INPUT 8'hCF
`define MASK_AUX 8'h9F
`define MASK_OUTPUT 8'hBF
`define MASK_SAMPLE_FORMAT 8'h7F
`define MASK_INTERFACE_CFG 8'h09
`define MASK_PIN_CONTROL 8'hE0
`define MASK_MISC_INFO 8'hC0
`define MASK_DIGITAL_MIX 8'hFD

// Bits still writable while mode change enable is low.
`define LOCK_SAMPLE_FORMAT 8'h00
`define LOCK_INTERFACE_CFG 8'h01
`define LOCK_MISC_INFO 8'h00

// Field positions.
`define BIT_MUTE 7
`define BIT_CLOCK_SOURCE 0
`define BIT_STEREO 4
`define BIT_COMPANDED 5
`define BIT_FORMAT 6
`define BIT_PLAYBACK 0
`define BIT_AUTOCAL 3
`define BIT_CLOCK_TRISTATE 5
`define BIT_SLOT_SELECT 6
`define BIT_FRAME_SIZE 7
`define BIT_MIX_ENABLE 0

// Level scaling in half-dB units: 1.5 dB per step, +12 dB aux offset.
`define STEP_HALF_DB 9'sd3
`define AUX_ZERO_HALF_DB 9'sd24

`endif

// File: logic/level_map.v
`timescale 1ns/100ps
`default_nettype none

// Turns the gain and attenuation codes into signed levels in half-dB units.
module level_map
(
  input wire clk,
  input wire sys_rst,
  input wire clk_en,
  input wire [3:0] left_in_gain,
  input wire [3:0] right_in_gain,
  input wire [19:0] aux_gains,
  input wire [5:0] left_out_atten,
  input wire [5:0] right_out_atten,
  output reg signed [8:0] left_in_level,
  output reg signed [8:0] right_in_level,
  output wire [35:0] aux_levels,
  output reg signed [8:0] left_out_level,
  output reg signed [8:0] right_out_level
);

`include "codec_consts.vh"

  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      left_in_level <= 9'sh000;
      right_in_level <= 9'sh000;
      left_out_level <= 9'sh000;
      right_out_level <= 9'sh000;
    end
    else if (clk_en)
    begin
      left_in_level <= $signed({5'h00, left_in_gain}) * `STEP_HALF_DB;
      right_in_level <= $signed({5'h00, right_in_gain}) * `STEP_HALF_DB;
      left_out_level <= -($signed({3'h0, left_out_atten}) * `STEP_HALF_DB);
      right_out_level <= -($signed({3'h0, right_out_atten}) * `STEP_HALF_DB);
    end
  end

  // Four auxiliary channels share one encoding: code 8 is unity gain.
  genvar a;
  generate
    for (a = 0; a < 4; a = a + 1)
    begin : aux_chan
      reg signed [8:0] level;
      always @(posedge clk or posedge sys_rst)
      begin
        if (sys_rst)
          level <= 9'sh000;
        else if (clk_en)
          level <= `AUX_ZERO_HALF_DB - $signed({4'h0, aux_gains[a*5 +: 5]}) * `STEP_HALF_DB;
      end
      assign aux_levels[a*9 +: 9] = level;
    end
  endgenerate

endmodule

`default_nettype wire

// File: logic/codec_index_regs.v
`timescale 1ns/100ps
`default_nettype none

module codec_index_regs
(
  input wire clk,
  input wire sys_rst,
  input wire clk_en,
  input wire ctrl_valid,
  input wire [15:0] ctrl_word,
  input wire [15:0] status_word,
  output reg readback_valid,
  output reg [15:0] readback_word,
  output reg mode_change_enable,
  output reg clear_overrange,
  output wire [1:0] left_source_sel,
  output wire [1:0] right_source_sel,
  output wire [3:0] left_in_gain,
  output wire [3:0] right_in_gain,
  output wire [4:0] left_aux1_gain,
  output wire [4:0] right_aux1_gain,
  output wire [4:0] left_aux2_gain,
  output wire [4:0] right_aux2_gain,
  output wire left_aux1_mute,
  output wire right_aux1_mute,
  output wire left_aux2_mute,
  output wire right_aux2_mute,
  output wire [5:0] left_out_atten,
  output wire [5:0] right_out_atten,
  output wire left_out_mute,
  output wire right_out_mute,
  output reg left_dac_muted,
  output reg right_dac_muted,
  output wire clock_source_sel,
  output wire [2:0] rate_divide_sel,
  output wire stereo_sel,
  output wire companded_sel,
  output wire sample_format_sel,
  output wire playback_enable,
  output wire autocal_enable,
  output wire [1:0] ext_ctrl,
  output wire clock_tristate,
  output wire slot_select,
  output wire frame_size_sel,
  output wire [5:0] mix_atten,
  output wire mix_enable,
  output wire signed [8:0] left_in_level,
  output wire signed [8:0] right_in_level,
  output wire signed [8:0] left_aux1_level,
  output wire signed [8:0] right_aux1_level,
  output wire signed [8:0] left_aux2_level,
  output wire signed [8:0] right_aux2_level,
  output wire signed [8:0] left_out_level,
  output wire signed [8:0] right_out_level
);

`include "codec_consts.vh"

  // Reset value of each index.
  function [7:0] reset_value;
    input [3:0] idx;
    begin
      case (idx)
        `IDX_LEFT_INPUT: reset_value = `RST_INPUT;
        `IDX_RIGHT_INPUT: reset_value = `RST_INPUT;
        `IDX_LEFT_AUX1: reset_value = `RST_AUX;
        `IDX_RIGHT_AUX1: reset_value = `RST_AUX;
        `IDX_LEFT_AUX2: reset_value = `RST_AUX;
        `IDX_RIGHT_AUX2: reset_value = `RST_AUX;
        `IDX_LEFT_OUTPUT: reset_value = `RST_OUTPUT;
        `IDX_RIGHT_OUTPUT: reset_value = `RST_OUTPUT;
        `IDX_SAMPLE_FORMAT: reset_value = `RST_SAMPLE_FORMAT;
        `IDX_INTERFACE_CFG: reset_value = `RST_INTERFACE_CFG;
        `IDX_PIN_CONTROL: reset_value = `RST_PIN_CONTROL;
        `IDX_MISC_INFO: reset_value = `RST_MISC_INFO;
        `IDX_DIGITAL_MIX: reset_value = `RST_DIGITAL_MIX;
        default: reset_value = 8'h00;
      endcase
    end
  endfunction

  // Bits that exist in each register; reserved bits are never stored.
  function [7:0] field_mask;
    input [3:0] idx;
    begin
      case (idx)
        `IDX_LEFT_INPUT: field_mask = `MASK_INPUT;
        `IDX_RIGHT_INPUT: field_mask = `MASK_INPUT;
        `IDX_LEFT_AUX1: field_mask = `MASK_AUX;
        `IDX_RIGHT_AUX1: field_mask = `MASK_AUX;
        `IDX_LEFT_AUX2: field_mask = `MASK_AUX;
        `IDX_RIGHT_AUX2: field_mask = `MASK_AUX;
        `IDX_LEFT_OUTPUT: field_mask = `MASK_OUTPUT;
        `IDX_RIGHT_OUTPUT: field_mask = `MASK_OUTPUT;
        `IDX_SAMPLE_FORMAT: field_mask = `MASK_SAMPLE_FORMAT;
        `IDX_INTERFACE_CFG: field_mask = `MASK_INTERFACE_CFG;
        `IDX_PIN_CONTROL: field_mask = `MASK_PIN_CONTROL;
        `IDX_MISC_INFO: field_mask = `MASK_MISC_INFO;
        `IDX_DIGITAL_MIX: field_mask = `MASK_DIGITAL_MIX;
        default: field_mask = 8'h00;
      endcase
    end
  endfunction

  // Bits that may change while mode change enable is low.
  function [7:0] locked_mask;
    input [3:0] idx;
    begin
      case (idx)
        `IDX_SAMPLE_FORMAT: locked_mask = `LOCK_SAMPLE_FORMAT;
        `IDX_INTERFACE_CFG: locked_mask = `LOCK_INTERFACE_CFG;
        `IDX_MISC_INFO: locked_mask = `LOCK_MISC_INFO;
        default: locked_mask = field_mask(idx);
      endcase
    end
  endfunction

  wire word_clor = ctrl_word[`CW_CLOR_BIT];
  wire word_mce = ctrl_word[`CW_MCE_BIT];
  wire word_rreq = ctrl_word[`CW_RREQ_BIT];
  wire [3:0] register_index = ctrl_word[`CW_IDX_HI:`CW_IDX_LO];
  wire [7:0] word_data = ctrl_word[`CW_DATA_HI:0];
  wire take_word = ctrl_valid & clk_en;
  wire take_write = take_word & ~word_rreq;
  wire take_read = take_word & word_rreq;

  localparam [15:0] VALID_MAP = `IDX_VALID_MAP;

  wire [7:0] bank [0:15];

  // Each mapped index is its own byte of flip-flops. The write mask is picked by the
  // mode change enable bit of the same control word, so a word that sets the
  // bit may already change protected fields.
  genvar i;
  generate
    for (i = 0; i < 16; i = i + 1)
    begin : entry
      localparam [31:0] IDX_WIDE = i;
      localparam [3:0] IDX = IDX_WIDE[3:0];
      localparam [7:0] RST = reset_value(IDX);
      localparam [7:0] FULL = field_mask(IDX);
      localparam [7:0] LOCKED = locked_mask(IDX);
      if (VALID_MAP[i])
      begin : mapped
        reg [7:0] value;
        wire hit = take_write & (register_index == IDX);
        wire [7:0] wmask = word_mce ? FULL : LOCKED;
        always @(posedge clk or posedge sys_rst)
        begin
          if (sys_rst)
            value <= RST;
          else if (hit)
            value <= (value & ~wmask) | (word_data & wmask);
        end
        assign bank[i] = value;
      end
      else
      begin : unmapped
        // Writes aimed here are dropped; there is no storage.
        assign bank[i] = 8'h00;
      end
    end
  endgenerate

  wire index_valid = VALID_MAP[register_index];

  // Read back and echo of the control bits.
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      readback_valid <= 1'b0;
      readback_word <= `RST_READBACK;
      mode_change_enable <= `RST_MCE;
      clear_overrange <= `RST_CLOR;
    end
    else if (clk_en)
    begin
      readback_valid <= take_read;
      if (ctrl_valid)
      begin
        mode_change_enable <= word_mce;
        clear_overrange <= word_clor;
      end
      if (take_read)
      begin
        if (index_valid)
          readback_word <= {word_clor, word_mce, 1'b1, 1'b0, register_index,
                            bank[register_index]};
        else
          readback_word <= status_word;
      end
    end
  end

  // The outputs are silenced during mode change as well as by their own mute
  // bit. The mute is held apart from the auxiliary mutes on purpose.
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      left_dac_muted <= 1'b1;
      right_dac_muted <= 1'b1;
    end
    else if (clk_en)
    begin
      left_dac_muted <= bank[`IDX_LEFT_OUTPUT][`BIT_MUTE] | mode_change_enable;
      right_dac_muted <= bank[`IDX_RIGHT_OUTPUT][`BIT_MUTE] | mode_change_enable;
    end
  end

  assign left_source_sel = bank[`IDX_LEFT_INPUT][7:6];
  assign right_source_sel = bank[`IDX_RIGHT_INPUT][7:6];
  assign left_in_gain = bank[`IDX_LEFT_INPUT][3:0];
  assign right_in_gain = bank[`IDX_RIGHT_INPUT][3:0];
  assign left_aux1_gain = bank[`IDX_LEFT_AUX1][4:0];
  assign right_aux1_gain = bank[`IDX_RIGHT_AUX1][4:0];
  assign left_aux2_gain = bank[`IDX_LEFT_AUX2][4:0];
  assign right_aux2_gain = bank[`IDX_RIGHT_AUX2][4:0];
  assign left_aux1_mute = bank[`IDX_LEFT_AUX1][`BIT_MUTE];
  assign right_aux1_mute = bank[`IDX_RIGHT_AUX1][`BIT_MUTE];
  assign left_aux2_mute = bank[`IDX_LEFT_AUX2][`BIT_MUTE];
  assign right_aux2_mute = bank[`IDX_RIGHT_AUX2][`BIT_MUTE];
  assign left_out_atten = bank[`IDX_LEFT_OUTPUT][5:0];
  assign right_out_atten = bank[`IDX_RIGHT_OUTPUT][5:0];
  assign left_out_mute = bank[`IDX_LEFT_OUTPUT][`BIT_MUTE];
  assign right_out_mute = bank[`IDX_RIGHT_OUTPUT][`BIT_MUTE];
  assign clock_source_sel = bank[`IDX_SAMPLE_FORMAT][`BIT_CLOCK_SOURCE];
  assign rate_divide_sel = bank[`IDX_SAMPLE_FORMAT][3:1];
  assign stereo_sel = bank[`IDX_SAMPLE_FORMAT][`BIT_STEREO];
  assign companded_sel = bank[`IDX_SAMPLE_FORMAT][`BIT_COMPANDED];
  assign sample_format_sel = bank[`IDX_SAMPLE_FORMAT][`BIT_FORMAT];
  assign playback_enable = bank[`IDX_INTERFACE_CFG][`BIT_PLAYBACK];
  assign autocal_enable = bank[`IDX_INTERFACE_CFG][`BIT_AUTOCAL];
  assign ext_ctrl = bank[`IDX_PIN_CONTROL][7:6];
  assign clock_tristate = bank[`IDX_PIN_CONTROL][`BIT_CLOCK_TRISTATE];
  assign slot_select = bank[`IDX_MISC_INFO][`BIT_SLOT_SELECT];
  assign frame_size_sel = bank[`IDX_MISC_INFO][`BIT_FRAME_SIZE];
  assign mix_atten = bank[`IDX_DIGITAL_MIX][7:2];
  assign mix_enable = bank[`IDX_DIGITAL_MIX][`BIT_MIX_ENABLE];

  wire [35:0] aux_levels;

  level_map level_map_i
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .left_in_gain(left_in_gain),
    .right_in_gain(right_in_gain),
    .aux_gains({right_aux2_gain, left_aux2_gain, right_aux1_gain, left_aux1_gain}),
    .left_out_atten(left_out_atten),
    .right_out_atten(right_out_atten),
    .left_in_level(left_in_level),
    .right_in_level(right_in_level),
    .aux_levels(aux_levels),
    .left_out_level(left_out_level),
    .right_out_level(right_out_level)
  );

  assign left_aux1_level = aux_levels[8:0];
  assign right_aux1_level = aux_levels[17:9];
  assign left_aux2_level = aux_levels[26:18];
  assign right_aux2_level = aux_levels[35:27];

endmodule

`default_nettype wire

// File: test/codec_index_regs_chk.sv
`timescale 1ns/100ps
`default_nettype none
module codec_index_regs_chk
(
  input wire clk,
  input wire sys_rst,
  input wire clk_en,
  input wire ctrl_valid,
  input wire [15:0] ctrl_word,
  input wire [15:0] status_word,
  input wire readback_valid,
  input wire [15:0] readback_word,
  input wire mode_change_enable,
  input wire left_aux1_mute,
  input wire left_out_mute,
  input wire right_out_mute,
  input wire left_dac_muted,
  input wire clock_source_sel
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire take = ctrl_valid && clk_en;
  wire rd = take && ctrl_word[13];
  wire wr = take && !ctrl_word[13];
  wire [3:0] ix = ctrl_word[11:8];
  wire ok = ix != 4'hB && ix < 4'hE;
  property p_rb_echo;
    rd && ok |=> readback_valid && readback_word[15:8] == {$past(ctrl_word[15:14]), 2'b10, $past(ix)};
  endproperty
  a_rb_echo: assert property (p_rb_echo) else $error("readback echo wrong");
  property p_inval;
    rd && !ok |=> readback_valid && readback_word == $past(status_word);
  endproperty
  a_inval: assert property (p_inval) else $error("invalid index not status");
  property p_fmt_lock;
    wr && ix == 4'h8 && !ctrl_word[14] |=> $stable(clock_source_sel);
  endproperty
  a_fmt_lock: assert property (p_fmt_lock) else $error("format changed unlocked");
  property p_fmt_wr;
    wr && ix == 4'h8 && ctrl_word[14] |=> clock_source_sel == $past(ctrl_word[0]);
  endproperty
  a_fmt_wr: assert property (p_fmt_wr) else $error("clock source not written");
  property p_aux_mute;
    wr && ix == 4'h2 |=> left_aux1_mute == $past(ctrl_word[7]);
  endproperty
  a_aux_mute: assert property (p_aux_mute) else $error("aux mute not written");
  property p_lmute;
    wr && ix == 4'h6 |=> left_out_mute == $past(ctrl_word[7]);
  endproperty
  a_lmute: assert property (p_lmute) else $error("left mute not written");
  property p_rmute;
    wr && ix == 4'h7 |=> right_out_mute == $past(ctrl_word[7]) && $stable(left_out_mute);
  endproperty
  a_rmute: assert property (p_rmute) else $error("right mute not written");
  property p_mce;
    take |=> mode_change_enable == $past(ctrl_word[14]) ##1
      (left_dac_muted || !$past(mode_change_enable) || !$past(clk_en));
  endproperty
  a_mce: assert property (p_mce) else $error("mode change echo or mute wrong");
endmodule
bind codec_index_regs codec_index_regs_chk codec_index_regs_chk_i (.clk(clk), .sys_rst(sys_rst),
  .clk_en(clk_en), .ctrl_valid(ctrl_valid), .ctrl_word(ctrl_word), .status_word(status_word),
  .readback_valid(readback_valid), .readback_word(readback_word),
  .mode_change_enable(mode_change_enable), .left_aux1_mute(left_aux1_mute),
  .left_out_mute(left_out_mute), .right_out_mute(right_out_mute),
  .left_dac_muted(left_dac_muted), .clock_source_sel(clock_source_sel));
`default_nettype wire

// File: test/host_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_model
(
  input wire clk,
  output logic ctrl_valid,
  output logic [15:0] ctrl_word
);
  initial
  begin
    ctrl_valid = 1'b0;
    ctrl_word = 16'h0000;
  end
  task automatic send(input logic [15:0] w);
    @(negedge clk);
    ctrl_valid = 1'b1;
    ctrl_word = w;
    @(negedge clk);
    ctrl_valid = 1'b0;
    // A stale word would hide a decoder that ignores the strobe.
    ctrl_word = ~w;
  endtask
  // Protected writes always go out in mode-change state.
  task automatic write_reg(input logic [3:0] ix, input logic [7:0] d);
    send({4'h4, ix, d});
  endtask
endmodule
`default_nettype wire

// File: test/codec_index_regs_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module codec_index_regs_tb_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic [15:0] status_word = 16'h5A3C;
  wire ctrl_valid;
  wire [15:0] ctrl_word;
  wire readback_valid, mode_change_enable, left_dac_muted, clock_source_sel;
  wire clear_overrange, right_dac_muted, left_out_mute, right_out_mute;
  wire left_aux1_mute, right_aux1_mute, left_aux2_mute, right_aux2_mute;
  wire stereo_sel, companded_sel, sample_format_sel, playback_enable, autocal_enable;
  wire clock_tristate, slot_select, frame_size_sel, mix_enable;
  wire [15:0] readback_word;
  wire [1:0] left_source_sel, right_source_sel, ext_ctrl;
  wire [2:0] rate_divide_sel;
  wire [3:0] left_in_gain, right_in_gain;
  wire [4:0] left_aux1_gain, right_aux1_gain, left_aux2_gain, right_aux2_gain;
  wire [5:0] left_out_atten, right_out_atten, mix_atten;
  wire signed [8:0] left_in_level, left_aux1_level, right_aux2_level, left_out_level;
  wire signed [8:0] right_in_level, right_aux1_level, left_aux2_level, right_out_level;
  int n_fail = 0;
  int n_compared = 0;
  localparam logic [7:0] rst_val [16] = '{8'h00, 8'h00, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80,
    8'h80, 8'h00, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] keep [8] = '{8'hCF, 8'hCF, 8'h9F, 8'h9F, 8'h9F, 8'h9F, 8'hBF, 8'hBF};
  localparam logic [15:0] vmap = 16'h37FF;
  initial
  begin
    forever #25 clk = ~clk;
  end
  host_model host_model_i (.clk(clk), .ctrl_valid(ctrl_valid), .ctrl_word(ctrl_word));
  codec_index_regs codec_index_regs_i (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .ctrl_valid(ctrl_valid), .ctrl_word(ctrl_word), .status_word(status_word),
    .readback_valid(readback_valid), .readback_word(readback_word),
    .mode_change_enable(mode_change_enable), .clear_overrange(clear_overrange),
    .left_source_sel(left_source_sel), .right_source_sel(right_source_sel),
    .left_in_gain(left_in_gain), .right_in_gain(right_in_gain),
    .left_aux1_gain(left_aux1_gain), .right_aux1_gain(right_aux1_gain),
    .left_aux2_gain(left_aux2_gain), .right_aux2_gain(right_aux2_gain),
    .left_aux1_mute(left_aux1_mute), .right_aux1_mute(right_aux1_mute),
    .left_aux2_mute(left_aux2_mute), .right_aux2_mute(right_aux2_mute),
    .left_out_atten(left_out_atten), .right_out_atten(right_out_atten),
    .left_out_mute(left_out_mute), .right_out_mute(right_out_mute),
    .left_dac_muted(left_dac_muted), .right_dac_muted(right_dac_muted),
    .clock_source_sel(clock_source_sel), .rate_divide_sel(rate_divide_sel),
    .stereo_sel(stereo_sel), .companded_sel(companded_sel),
    .sample_format_sel(sample_format_sel), .playback_enable(playback_enable),
    .autocal_enable(autocal_enable), .ext_ctrl(ext_ctrl), .clock_tristate(clock_tristate),
    .slot_select(slot_select), .frame_size_sel(frame_size_sel), .mix_atten(mix_atten),
    .mix_enable(mix_enable), .left_in_level(left_in_level), .right_in_level(right_in_level),
    .left_aux1_level(left_aux1_level), .right_aux1_level(right_aux1_level),
    .left_aux2_level(left_aux2_level), .right_aux2_level(right_aux2_level),
    .left_out_level(left_out_level), .right_out_level(right_out_level));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [3:0] ix, output logic [15:0] q);
    host_model_i.send({4'hE, ix, 8'h00});
    chk({15'h0000, readback_valid}, 16'h0001);
    q = readback_word;
  endtask
  task automatic t_reset;
    logic [15:0] q;
    for (int i = 0; i < 16; i++)
    begin
      rd(i[3:0], q);
      chk(q, vmap[i] ? {4'hE, i[3:0], rst_val[i]} : status_word);
    end
  endtask
  task automatic t_mask;
    logic [15:0] q;
    for (int i = 0; i < 8; i++)
    begin
      host_model_i.write_reg(i[3:0], keep[i]);
      rd(i[3:0], q);
      chk(q, {4'hE, i[3:0], keep[i]});
    end
    chk({12'h000, left_in_gain}, 16'h000F);
    chk({7'h00, left_in_level}, 16'h002D);
    chk({7'h00, left_aux1_level}, 16'h01BB);
    chk({7'h00, left_out_level}, 16'h0143);
    host_model_i.write_reg(4'h5, 8'h08);
    @(negedge clk);
    chk({7'h00, right_aux2_level}, 16'h0000);
  endtask
  task automatic t_source;
    for (int s = 0; s < 4; s++)
    begin
      host_model_i.write_reg(4'h0, {s[1:0], 6'h03});
      chk({14'h0000, left_source_sel}, s[15:0]);
    end
  endtask
  task automatic t_fmt;
    logic [15:0] q;
    host_model_i.write_reg(4'h6, 8'h00);
    // Same index and data as the later legal write, only the mode bit differs.
    host_model_i.send(16'h0801);
    chk({15'h0000, mode_change_enable}, 16'h0000);
    @(negedge clk);
    chk({15'h0000, left_dac_muted}, 16'h0000);
    chk({15'h0000, clock_source_sel}, 16'h0000);
    rd(4'h8, q);
    chk(q, 16'hE800);
    clk_en = 1'b0;
    host_model_i.write_reg(4'h8, 8'h01);
    clk_en = 1'b1;
    chk({15'h0000, clock_source_sel}, 16'h0000);
    host_model_i.write_reg(4'h8, 8'h01);
    chk({15'h0000, clock_source_sel}, 16'h0001);
  endtask
  task automatic t_fields;
    logic [15:0] q;
    host_model_i.write_reg(4'h1, 8'hC5);
    host_model_i.write_reg(4'h2, 8'h00);
    host_model_i.write_reg(4'h3, 8'h1F);
    host_model_i.write_reg(4'h4, 8'h8A);
    host_model_i.write_reg(4'h5, 8'h81);
    host_model_i.write_reg(4'h7, 8'h3F);
    host_model_i.write_reg(4'hB, 8'h55);
    @(negedge clk);
    chk({14'h0000, right_source_sel}, 16'h0003);
    chk({12'h000, right_in_gain}, 16'h0005);
    chk({7'h00, right_in_level}, 16'h000F);
    chk({6'h00, left_aux1_gain, right_aux1_gain}, 16'h001F);
    chk({7'h00, left_aux1_level}, 16'h0018);
    chk({7'h00, right_aux1_level}, 16'h01BB);
    chk({6'h00, left_aux2_gain, right_aux2_gain}, 16'h0141);
    chk({7'h00, left_aux2_level}, 16'h01FA);
    chk({7'h00, right_aux2_level}, 16'h0015);
    chk({12'h000, left_aux1_mute, right_aux1_mute, left_aux2_mute,
      right_aux2_mute}, 16'h0003);
    chk({4'h0, left_out_atten, right_out_atten}, 16'h003F);
    chk({7'h00, right_out_level}, 16'h0143);
    chk({14'h0000, left_out_mute, right_out_mute}, 16'h0000);
    // Index 11 aliases index 3 in its low bits; the dropped write must not land there.
    rd(4'h3, q);
    chk(q, 16'hE31F);
    host_model_i.send(16'hA700);
    chk(readback_word, 16'hA73F);
    chk({15'h0000, clear_overrange}, 16'h0001);
    @(negedge clk);
    chk({14'h0000, left_dac_muted, right_dac_muted}, 16'h0000);
    host_model_i.send(16'h0780);
    @(negedge clk);
    chk({14'h0000, left_dac_muted, right_dac_muted}, 16'h0001);
    chk({15'h0000, clear_overrange}, 16'h0000);
    host_model_i.send(16'h0901);
    host_model_i.send(16'h0CC0);
    host_model_i.send(16'h0AE0);
    host_model_i.send(16'h0DFD);
    chk({14'h0000, playback_enable, autocal_enable}, 16'h0003);
    chk({14'h0000, slot_select, frame_size_sel}, 16'h0000);
    chk({13'h0000, ext_ctrl, clock_tristate}, 16'h0007);
    chk({9'h000, mix_atten, mix_enable}, 16'h007F);
    host_model_i.write_reg(4'h8, 8'h7E);
    host_model_i.write_reg(4'h9, 8'h00);
    host_model_i.write_reg(4'hC, 8'hC0);
    chk({9'h000, sample_format_sel, companded_sel, stereo_sel, rate_divide_sel,
      clock_source_sel}, 16'h007E);
    chk({14'h0000, playback_enable, autocal_enable}, 16'h0000);
    chk({14'h0000, slot_select, frame_size_sel}, 16'h0003);
  endtask
  task automatic final_report;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    t_reset();
    t_mask();
    t_source();
    t_fmt();
    t_fields();
    final_report();
  end
  initial
  begin
    #(5000 * 50);
    n_fail++;
    final_report();
  end
endmodule
`default_nettype wire
